// [fault_wake_status.v]
// fault and wake status word of the analog die, returned on the serial link
// assumes the link master drives slave select, serial clock and data as pins
// on no particular clock; the analog detectors give asynchronous levels

`include "fault_wake_status_defines.vh"

//
// Contract
// [R1] indicator high: low bits show interrupt sources
// [R2] no interrupt: indicator zero, bits show live
// [R3] lin flag set on wake or lin fault
// [R4] lin fault disables the lin transmitter
// [R5] transmitter back after fault gone, flag cleared
// [R6] reading set lin flag clears it
// [R7] over-voltage bit follows supply over threshold
// [R8] under-voltage bit follows supply under threshold
// [R9] prewarn bit follows regulator over-temperature
// [R10] thermal bit set when any high side hot
// [R11] any high side hot disables all switches
// [R12] restore needs clearing read then switch-on write
// [R13] wake bits show live wake pin levels
// [R14] after wake, wake bits name the cause
// [R15] indicator on bit seven, info below
// [R16] word captured at slave select falling edge
// [R17] first read after reset shows battery fail
// [R18] transfer valid only with eight sampling edges
// [R19] status shifted out most significant first
module fault_wake_status (
    input  wire       clk,
    input  wire       reset,
    input  wire       ss_n,
    input  wire       sck,
    input  wire       mosi,
    output wire       miso_out,
    output wire       miso_oe_n,
    input  wire       lin_wake_evt,
    input  wire       lin_fault,
    input  wire       supply_over,
    input  wire       supply_under,
    input  wire       battery_fail_state,
    input  wire       reg_temp_prewarn,
    input  wire [2:0] hs_over_temp,
    input  wire [1:0] wake_in,
    input  wire [1:0] wake_by_input,
    output wire       lin_tx_enable,
    output wire [2:0] high_side_on,
    output wire [7:0] control_byte,
    output wire       xfer_done
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    wire [`FWS_SYNC_W-1:0] async_in;
    reg  [`FWS_SYNC_W-1:0] meta_r;
    reg  [`FWS_SYNC_W-1:0] sync_r;
    reg  [`FWS_SYNC_W-1:0] prev_r;

    assign async_in = {ss_n, sck, mosi, lin_wake_evt, lin_fault, supply_over,
                       supply_under, battery_fail_state, reg_temp_prewarn,
                       hs_over_temp, wake_in, wake_by_input};

    // reset image: select idle high, every other pin low
    localparam [`FWS_SYNC_W-1:0] sync_init = `FWS_SYNC_INIT;

    // two flops per pin, then one more stage for edge detection
    genvar gi;
    generate
        for (gi = 0; gi < `FWS_SYNC_W; gi = gi + 1) begin : g_sync
            always @(posedge clk or posedge reset) begin
                if (reset) begin
                    meta_r[gi] <= sync_init[gi];
                    sync_r[gi] <= sync_init[gi];
                    prev_r[gi] <= sync_init[gi];
                end else begin
                    meta_r[gi] <= async_in[gi];
                    sync_r[gi] <= meta_r[gi];
                    prev_r[gi] <= sync_r[gi];
                end
            end
        end
    endgenerate

    // named views of the synchronised vector
    wire       ss_s       = sync_r[`FWS_SYNC_SS];
    wire       sck_s      = sync_r[`FWS_SYNC_SCK];
    wire       mosi_s     = sync_r[`FWS_SYNC_MOSI];
    wire       lin_wk_s   = sync_r[`FWS_SYNC_LIN_WAKE];
    wire       lin_flt_s  = sync_r[`FWS_SYNC_LIN_FAULT];
    wire       ov_s       = sync_r[`FWS_SYNC_OV];
    wire       uv_s       = sync_r[`FWS_SYNC_UV];
    wire       batf_s     = sync_r[`FWS_SYNC_BATF];
    wire       prew_s     = sync_r[`FWS_SYNC_PREWARN];
    wire [2:0] hs_ot_s    = sync_r[`FWS_SYNC_HS_MSB:`FWS_SYNC_HS_LSB];
    wire [1:0] wake_lvl_s = sync_r[`FWS_SYNC_WAKE_MSB:`FWS_SYNC_WAKE_LSB];
    wire [1:0] wake_by_s  = sync_r[`FWS_SYNC_WBY_MSB:`FWS_SYNC_WBY_LSB];
    wire [1:0] wake_by_p  = prev_r[`FWS_SYNC_WBY_MSB:`FWS_SYNC_WBY_LSB];

    // edges of the link pins and event rises
    wire ss_fall  = prev_r[`FWS_SYNC_SS] & ~ss_s;
    wire ss_rise  = ~prev_r[`FWS_SYNC_SS] & ss_s;
    wire sck_rise = ~prev_r[`FWS_SYNC_SCK] & sck_s & ~ss_s;
    wire sck_fall = prev_r[`FWS_SYNC_SCK] & ~sck_s & ~ss_s;
    wire hs_hot   = |hs_ot_s;
    wire lin_evt  = (lin_wk_s & ~prev_r[`FWS_SYNC_LIN_WAKE])
                  | (lin_flt_s & ~prev_r[`FWS_SYNC_LIN_FAULT]);
    wire [6:0] src_set = {lin_evt,
                          ov_s & ~prev_r[`FWS_SYNC_OV],
                          uv_s & ~prev_r[`FWS_SYNC_UV],
                          prew_s & ~prev_r[`FWS_SYNC_PREWARN],
                          hs_hot & ~(|prev_r[`FWS_SYNC_HS_MSB:`FWS_SYNC_HS_LSB]),
                          wake_by_s & ~wake_by_p};

    // ************************************************************
    // state registers
    // ************************************************************
    reg  [6:0] int_src_r;
    reg        lin_flag_r;
    reg        lin_tx_off_r;
    reg        hs_flag_r;
    reg        hs_off_r;
    reg        first_read_r;
    reg  [7:0] cap_r;
    reg  [7:0] rx_r;
    reg  [3:0] fall_cnt_r;
    reg        miso_r;
    reg        oe_n_r;
    reg  [7:0] ctrl_r;
    reg        done_r;
    reg  [7:0] word_nxt;

    wire interrupt_source_indicator = |int_src_r;
    wire valid_end = ss_rise & (fall_cnt_r == `FWS_XFER_EDGES);   // R18

    // ************************************************************
    // status word assembly
    // ************************************************************
    // source view when an interrupt is pending, live view otherwise
    always @* begin
        if (interrupt_source_indicator) begin
            word_nxt = {1'b1, int_src_r};                         // R1 R14 R15
        end else begin
            word_nxt = `FWS_WORD_RESET;                           // R2
            word_nxt[`FWS_LIN_BIT]      = lin_flag_r;
            word_nxt[`FWS_OV_BIT]       = ov_s;                   // R7
            word_nxt[`FWS_UV_BIT]       = first_read_r ? batf_s : uv_s; // R8 R17
            word_nxt[`FWS_PREWARN_BIT]  = prew_s;                 // R9
            word_nxt[`FWS_HS_THERM_BIT] = hs_flag_r;              // R10
            word_nxt[`FWS_WAKE2_BIT]    = wake_lvl_s[1];          // R13
            word_nxt[`FWS_WAKE1_BIT]    = wake_lvl_s[0];          // R13
        end
    end

    // ************************************************************
    // serial shifter
    // ************************************************************
    // capture at select fall, drive on clock rise, sample on clock fall
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cap_r      <= `FWS_WORD_RESET;
            rx_r       <= `FWS_CTRL_RESET;
            fall_cnt_r <= 4'h0;
            miso_r     <= 1'b0;
            oe_n_r     <= 1'b1;
        end else if (ss_fall) begin
            cap_r      <= word_nxt;                               // R16
            fall_cnt_r <= 4'h0;
            miso_r     <= word_nxt[`FWS_INDICATOR_BIT];           // R19
            oe_n_r     <= 1'b0;
        end else if (ss_s) begin
            oe_n_r     <= 1'b1;
        end else begin
            if (sck_rise && fall_cnt_r < `FWS_XFER_EDGES) begin
                miso_r <= cap_r[3'h7 - fall_cnt_r[2:0]];          // R19
            end
            if (sck_fall) begin
                rx_r <= {rx_r[6:0], mosi_s};
                if (fall_cnt_r != 4'hF) begin
                    fall_cnt_r <= fall_cnt_r + 4'h1;              // R18
                end
            end
        end
    end

    // ************************************************************
    // control byte and transfer completion
    // ************************************************************
    // only a complete eight-edge transfer updates the control byte
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_r       <= `FWS_CTRL_RESET;
            done_r       <= 1'b0;
            first_read_r <= 1'b1;
        end else begin
            done_r <= valid_end;
            if (valid_end) begin
                ctrl_r       <= rx_r;                             // R18
                first_read_r <= 1'b0;                             // R17
            end
        end
    end

    // ************************************************************
    // sticky flags, read-to-clear, set wins
    // ************************************************************
    // interrupt sources clear only for bits that the read returned
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            int_src_r  <= `FWS_SRC_RESET;
            lin_flag_r <= 1'b0;
            hs_flag_r  <= 1'b0;
        end else begin
            int_src_r <= (valid_end && cap_r[7] ? int_src_r & ~cap_r[6:0] : int_src_r)
                         | src_set;                               // R1 R14
            if (lin_evt) begin
                lin_flag_r <= 1'b1;                               // R3
            end else if (valid_end && cap_r[`FWS_LIN_BIT]) begin
                lin_flag_r <= 1'b0;                               // R6
            end
            if (hs_hot) begin
                hs_flag_r <= 1'b1;                                // R10
            end else if (valid_end && cap_r[`FWS_HS_THERM_BIT]) begin
                hs_flag_r <= 1'b0;                                // R12
            end
        end
    end

    // ************************************************************
    // lin transmitter and high side shutdown
    // ************************************************************
    // outputs stay off until the recovery sequence completes
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            lin_tx_off_r <= 1'b0;
            hs_off_r     <= 1'b0;
        end else begin
            if (lin_flt_s) begin
                lin_tx_off_r <= 1'b1;                             // R4
            end else if (!lin_flag_r) begin
                lin_tx_off_r <= 1'b0;                             // R5
            end
            if (hs_hot) begin
                hs_off_r <= 1'b1;                                 // R11
            end else if (!hs_flag_r && valid_end
                         && |rx_r[`FWS_HS_ON_MSB:`FWS_HS_ON_LSB]) begin
                hs_off_r <= 1'b0;                                 // R12
            end
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign miso_out      = miso_r;
    assign miso_oe_n     = oe_n_r;
    assign lin_tx_enable = ~lin_tx_off_r;
    assign high_side_on  = ctrl_r[`FWS_HS_ON_MSB:`FWS_HS_ON_LSB]
                           & {3{~hs_off_r}};                      // R11
    assign control_byte  = ctrl_r;
    assign xfer_done     = done_r;

endmodule // fault_wake_status

// [fault_wake_status_defines.vh]
// constants for the fault and wake status word returned over the serial link
// assumes a single 20 MHz system clock samples every link and analog pin
`ifndef FAULT_WAKE_STATUS_DEFINES_VH
`define FAULT_WAKE_STATUS_DEFINES_VH

// ************************************************************
// status word bit positions
// ************************************************************
`define FWS_INDICATOR_BIT   3'd7
`define FWS_LIN_BIT         3'd6
`define FWS_OV_BIT          3'd5
`define FWS_UV_BIT          3'd4
`define FWS_PREWARN_BIT     3'd3
`define FWS_HS_THERM_BIT    3'd2
`define FWS_WAKE2_BIT       3'd1
`define FWS_WAKE1_BIT       3'd0

// ************************************************************
// control byte field positions (write side)
// ************************************************************
`define FWS_HS_ON_LSB       2
`define FWS_HS_ON_MSB       4

// ************************************************************
// transfer framing and reset values
// ************************************************************
`define FWS_XFER_EDGES      4'h8
`define FWS_CTRL_RESET      8'h00
`define FWS_WORD_RESET      8'h00
`define FWS_SRC_RESET       7'h00

// ************************************************************
// synchroniser layout: index of each pin in the sampled vector
// ************************************************************
`define FWS_SYNC_W          16
`define FWS_SYNC_INIT       16'h8000
`define FWS_SYNC_SS         15
`define FWS_SYNC_SCK        14
`define FWS_SYNC_MOSI       13
`define FWS_SYNC_LIN_WAKE   12
`define FWS_SYNC_LIN_FAULT  11
`define FWS_SYNC_OV         10
`define FWS_SYNC_UV         9
`define FWS_SYNC_BATF       8
`define FWS_SYNC_PREWARN    7
`define FWS_SYNC_HS_MSB     6
`define FWS_SYNC_HS_LSB     4
`define FWS_SYNC_WAKE_MSB   3
`define FWS_SYNC_WAKE_LSB   2
`define FWS_SYNC_WBY_MSB    1
`define FWS_SYNC_WBY_LSB    0
`define FWS_CLK_PERIOD_NS   50

`endif

// [fault_wake_status_chk.sv]
// checker for the fault and wake status block
// assumes it is bound onto fault_wake_status, one clock domain
module fws_chk (
    input logic       clk,
    input logic       reset,
    input logic       ss_n,
    input logic       lin_fault,
    input logic [2:0] hs_over_temp,
    input logic       miso_oe_n,
    input logic       lin_tx_enable,
    input logic [2:0] high_side_on,
    input logic [7:0] control_byte,
    input logic       xfer_done
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // ****
    // link and shutdown relations
    // ****
    property p_lin_off; lin_fault [*5] |-> !lin_tx_enable; endproperty
    a_lin_off: assert property (p_lin_off) else $error("lin tx on in fault");
    property p_lin_back; $rose(lin_tx_enable) |-> !$past(lin_fault, 3); endproperty
    a_lin_back: assert property (p_lin_back) else $error("lin tx back early");
    property p_hs_off; (|hs_over_temp) [*5] |-> high_side_on == 3'h0; endproperty
    a_hs_off: assert property (p_hs_off) else $error("high side on when hot");
    property p_hs_arm; $rose(|high_side_on) |-> xfer_done || $past(xfer_done); endproperty
    a_hs_arm: assert property (p_hs_arm) else $error("high side on without write");
    property p_oe_on; $fell(ss_n) |-> ##[2:5] !miso_oe_n; endproperty
    a_oe_on: assert property (p_oe_on) else $error("miso not driven");
    property p_oe_off; ss_n [*6] |-> miso_oe_n; endproperty
    a_oe_off: assert property (p_oe_off) else $error("miso driven when idle");
    property p_done; xfer_done |-> ss_n && $past(ss_n, 3); endproperty
    a_done: assert property (p_done) else $error("done inside frame");
    property p_ctrl; $changed(control_byte) |-> xfer_done; endproperty
    a_ctrl: assert property (p_ctrl) else $error("control changed alone");
    // main scenarios seen
    c_done: cover property (xfer_done);
    c_lin: cover property ($fell(lin_tx_enable));
    c_hs: cover property ($rose(|high_side_on));
endmodule // fws_chk

bind fault_wake_status fws_chk u_chk (.clk(clk), .reset(reset), .ss_n(ss_n),
    .lin_fault(lin_fault), .hs_over_temp(hs_over_temp), .miso_oe_n(miso_oe_n),
    .lin_tx_enable(lin_tx_enable), .high_side_on(high_side_on),
    .control_byte(control_byte), .xfer_done(xfer_done));

// [spi_master_model.sv]
// serial link master facing the status block
// assumes the caller starts a frame 1 ns after a clock edge
module spi_master_model (
    output logic ss_n,
    output logic sck,
    output logic mosi,
    input  logic miso_out,
    input  logic miso_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ss_n = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
    end
    // one frame of n sampling edges, 400 ns link clock
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        ss_n = 1'b0;
        #300;
        for (int i = 0; i < n; i++) begin
            sck = 1'b1;
            mosi = tx[7 - i];
            #200;
            sck = 1'b0;
            #200;
            rx = {rx[6:0], miso_oe_n ? ~miso_out : miso_out}; // undriven line reads wrong
        end
        #150;
        ss_n = 1'b1;
        mosi = ~mosi; // released line shows no stale bit
        #350;
    endtask
endmodule // spi_master_model

// [spi_fault_wake_status_tb_top.sv]
// testbench for the fault and wake status block
// assumes a 20 MHz clock and the link master model beside it
module spi_fault_wake_status_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, reset, ss_n, sck, mosi, miso_out, miso_oe_n;
    logic       lin_wake_evt, lin_fault, supply_over, supply_under;
    logic       battery_fail_state, reg_temp_prewarn, lin_tx_enable, xfer_done;
    logic [2:0] hs_over_temp, high_side_on;
    logic [1:0] wake_in, wake_by_input;
    logic [7:0] control_byte, rx;
    int         mismatches, num_checks;
    fault_wake_status dut (.clk(clk), .reset(reset), .ss_n(ss_n), .sck(sck), .mosi(mosi),
        .miso_out(miso_out), .miso_oe_n(miso_oe_n), .lin_wake_evt(lin_wake_evt),
        .lin_fault(lin_fault), .supply_over(supply_over), .supply_under(supply_under),
        .battery_fail_state(battery_fail_state), .reg_temp_prewarn(reg_temp_prewarn),
        .hs_over_temp(hs_over_temp), .wake_in(wake_in), .wake_by_input(wake_by_input),
        .lin_tx_enable(lin_tx_enable), .high_side_on(high_side_on),
        .control_byte(control_byte), .xfer_done(xfer_done));
    spi_master_model m (.ss_n(ss_n), .sck(sck), .mosi(mosi), .miso_out(miso_out),
        .miso_oe_n(miso_oe_n));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ****
    // helpers
    // ****
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] tx, input logic [7:0] exp);
        m.xfer(tx, 8, rx);
        cyc(4);
        chk(rx, exp);
    endtask
    // ****
    // scenarios
    // ****
    task t_supply;
        rd(8'h00, 8'h11);
        rd(8'h00, 8'h01);
        supply_over = 1'b1;
        cyc(5);
        rd(8'h00, 8'hA0);
        rd(8'h00, 8'h21);
        supply_over = 1'b0;
        supply_under = 1'b1;
        reg_temp_prewarn = 1'b1;
        cyc(5);
        rd(8'h00, 8'h98);
        rd(8'h00, 8'h19);
        supply_under = 1'b0;
        reg_temp_prewarn = 1'b0;
        cyc(5);
        rd(8'h00, 8'h01);
        $display("test supply done");
    endtask
    task t_lin;
        lin_fault = 1'b1;
        cyc(6);
        chk(8'(lin_tx_enable), 8'h00);
        lin_fault = 1'b0;
        cyc(6);
        chk(8'(lin_tx_enable), 8'h00);
        rd(8'h00, 8'hC0);
        chk(8'(lin_tx_enable), 8'h01);
        rd(8'h00, 8'h01);
        lin_wake_evt = 1'b1;
        cyc(5);
        lin_wake_evt = 1'b0;
        rd(8'h00, 8'hC0);
        rd(8'h00, 8'h01);
        $display("test lin done");
    endtask
    task t_hs;
        rd(8'h1C, 8'h01);
        chk(8'(high_side_on), 8'h07);
        hs_over_temp = 3'b010;
        cyc(6);
        chk(8'(high_side_on), 8'h00);
        rd(8'h1C, 8'h84);
        rd(8'h1C, 8'h05);
        hs_over_temp = 3'b000;
        cyc(5);
        rd(8'h1C, 8'h05);
        chk(8'(high_side_on), 8'h00);
        rd(8'h1C, 8'h01);
        chk(8'(high_side_on), 8'h07);
        $display("test high side done");
    endtask
    task t_wake;
        wake_by_input = 2'b10;
        wake_in = 2'b10;
        cyc(5);
        m.xfer(8'hFF, 7, rx);
        cyc(4);
        chk(control_byte, 8'h1C);
        rd(8'h00, 8'h82);
        rd(8'h00, 8'h02);
        $display("test wake done");
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // main sequence
    initial begin
        {lin_wake_evt, lin_fault, supply_over, supply_under, reg_temp_prewarn} = 5'h00;
        battery_fail_state = 1'b1;
        hs_over_temp = 3'b000;
        wake_in = 2'b01;
        wake_by_input = 2'b00;
        reset = 1'b1;
        repeat (2) @(posedge clk);
        #1 reset = 1'b0;
        cyc(1);
        t_supply;
        t_lin;
        t_hs;
        t_wake;
        end_of_test;
    end
    // hang guard
    initial begin
        #500000;
        mismatches++;
        end_of_test;
    end
endmodule // spi_fault_wake_status_tb_top
